// ==== core/radio_time_pkg.sv ====
/*
 * Package for the radio base time target block: register map, field
 * positions, reset values, bus carrier struct and sequencer states.
 * Assumes a 32-bit register port with byte addresses as printed.
 */
package radio_time_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] PREFETCH_LEAD_TIME_ADDR  = 32'h4000_00f0;
   localparam logic [31:0] COARSE_TIMER_TARGET_ADDR = 32'h4000_00f4;
   localparam logic [31:0] SLOT_TIMER_TARGET_ADDR   = 32'h4000_00f8;
   localparam logic [31:0] TIME_CAPTURE_TRIG_ADDR   = 32'h4000_00fc;
   localparam logic [31:0] LINK_CONTROL_TWO_ADDR    = 32'h4000_0200;
   localparam logic [31:0] BASE_TIME_COUNT_ADDR     = 32'h4000_0204;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int LEAD_W          = 8;
   localparam int COARSE_W        = 16;
   localparam int BASE_W          = 27;
   localparam int RSSI_W          = 8;
   localparam int COARSE_LO       = 4;
   localparam int COARSE_HI       = 19;
   localparam int CAPTURE_BIT     = 0;
   localparam int RSSI_SEL_BIT    = 21;
   localparam int WAKE_STAT_BIT   = 20;
   localparam int TEST_LO         = 17;
   localparam int TEST_HI         = 19;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [LEAD_W-1:0]   LEAD_RST     = 8'h00;
   localparam logic [COARSE_W-1:0] COARSE_RST   = 16'h0000;
   localparam logic [BASE_W-1:0]   BASE_RST     = 27'h000_0000;
   localparam logic [2:0]          TEST_RST     = 3'h0;
   localparam logic [RSSI_W-1:0]   RSSI_RST     = 8'h00;
   localparam logic [31:0]         READ_ZERO    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carrier and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef enum logic [1:0] {
      ACK_IDLE,
      ACK_WAIT_EDGE,
      ACK_WAIT_PERIOD
   } ack_state_t;

endpackage : radio_time_pkg

// ==== core/radio_base_time_targets.sv ====
/*
 * Base time target compare, capture, prefetch lead time, signal
 * strength selection and low-power wakeup status for the radio link
 * controller. Assumes base time count and signal strength values come
 * from logic on sys_clk_in; the lp clock, wakeup and power-up lines
 * come from other domains and are synchronised here.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module radio_base_time_targets
   import radio_time_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   // register port
   input  wire reg_req_t          reg_req_in,
   output logic [31:0]            reg_rdata_out,
   // time base and signal strength
   input  wire logic [BASE_W-1:0] base_time_count_in,
   input  wire logic [RSSI_W-1:0] rssi_peak_in,
   input  wire logic [RSSI_W-1:0] rssi_avg_in,
   // low-power domain lines
   input  wire logic              lp_clk_in,
   input  wire logic              lp_wakeup_irq_in,
   input  wire logic              radio_powered_up_in,
   // outputs to the link engine
   output logic [LEAD_W-1:0]      prefetch_lead_us_out,
   output logic                   coarse_match_irq_out,
   output logic                   slot_match_irq_out,
   output logic [RSSI_W-1:0]      rssi_value_out,
   output logic                   lp_wakeup_status_out,
   output logic [2:0]             test_bits_out
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [COARSE_W-1:0] coarse_target;
   logic [BASE_W-1:0]   slot_target;
   logic [BASE_W-1:0]   base_time_count;
   logic                capture_trigger;
   logic                signal_strength_select;
   logic                coarse_hit;
   logic                slot_hit;
   logic                coarse_hit_q;
   logic                slot_hit_q;
   logic [2:0]          lp_clk_s;
   logic [2:0]          wake_s;
   logic [2:0]          pwr_s;
   logic                lp_rise;
   logic                wake_rise;
   logic                pwr_rise;
   logic                wake_ack;
   ack_state_t          ack_state;
   ack_state_t          next_ack_state;

   function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
      return reg_req_in.wr && (a == b);
   endfunction : hit

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // lead time store
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         prefetch_lead_us_out <= LEAD_RST;
      end else if (hit(reg_req_in.addr, PREFETCH_LEAD_TIME_ADDR)) begin
         prefetch_lead_us_out <= reg_req_in.wdata[LEAD_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         coarse_target <= COARSE_RST;
      end else if (hit(reg_req_in.addr, COARSE_TIMER_TARGET_ADDR)) begin
         coarse_target <= reg_req_in.wdata[COARSE_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         slot_target <= BASE_RST;
      end else if (hit(reg_req_in.addr, SLOT_TIMER_TARGET_ADDR)) begin
         slot_target <= reg_req_in.wdata[BASE_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         signal_strength_select <= 1'b0;
         test_bits_out          <= TEST_RST;
      end else if (hit(reg_req_in.addr, LINK_CONTROL_TWO_ADDR)) begin
         signal_strength_select <= reg_req_in.wdata[RSSI_SEL_BIT];
         // test bits are stored only; they steer nothing in this block
         test_bits_out          <= reg_req_in.wdata[TEST_HI:TEST_LO];
      end
   end

   // ----------------------------------------------------------------
   // capture of the base time counter
   // ----------------------------------------------------------------
   // self clear, new write wins
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         capture_trigger <= 1'b0;
      end else if (hit(reg_req_in.addr, TIME_CAPTURE_TRIG_ADDR)
                   && reg_req_in.wdata[CAPTURE_BIT]) begin
         capture_trigger <= 1'b1;
      end else if (capture_trigger) begin
         capture_trigger <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         base_time_count <= BASE_RST;
      end else if (capture_trigger) begin
         base_time_count <= base_time_count_in;
      end
   end

   // ----------------------------------------------------------------
   // target compare
   // ----------------------------------------------------------------
   // coarse equality
   assign coarse_hit = (coarse_target == base_time_count_in[COARSE_HI:COARSE_LO])
                       && (base_time_count_in[COARSE_LO-1:0] == 4'h0);
   assign slot_hit   = (slot_target == base_time_count_in);

   // one pulse per match, on the rising condition
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         coarse_hit_q         <= 1'b0;
         slot_hit_q           <= 1'b0;
         coarse_match_irq_out <= 1'b0;
         slot_match_irq_out   <= 1'b0;
      end else begin
         coarse_hit_q         <= coarse_hit;
         slot_hit_q           <= slot_hit;
         coarse_match_irq_out <= coarse_hit && !coarse_hit_q;
         slot_match_irq_out   <= slot_hit && !slot_hit_q;
      end
   end

   // ----------------------------------------------------------------
   // signal strength selection
   // ----------------------------------------------------------------
   // peak-hold or average
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         rssi_value_out <= RSSI_RST;
      end else begin
         rssi_value_out <= signal_strength_select ? rssi_avg_in : rssi_peak_in;
      end
   end

   // ----------------------------------------------------------------
   // low-power wakeup status and acknowledge
   // ----------------------------------------------------------------
   // stage 0 feeds only stage 1; edges are taken from stages 1 and 2
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         lp_clk_s <= 3'h0;
         wake_s   <= 3'h0;
         pwr_s    <= 3'h0;
      end else begin
         lp_clk_s <= {lp_clk_s[1:0], lp_clk_in};
         wake_s   <= {wake_s[1:0], lp_wakeup_irq_in};
         pwr_s    <= {pwr_s[1:0], radio_powered_up_in};
      end
   end

   assign lp_rise   = lp_clk_s[1] && !lp_clk_s[2];
   assign wake_rise = wake_s[1] && !wake_s[2];
   assign pwr_rise  = pwr_s[1] && !pwr_s[2];

   // waiting for two lp edges guarantees a whole lp period has passed
   always_comb begin
      next_ack_state = ack_state;
      wake_ack       = 1'b0;
      case (ack_state)
         ACK_IDLE: begin
            if (pwr_rise && lp_wakeup_status_out) begin
               next_ack_state = ACK_WAIT_EDGE;
            end
         end
         ACK_WAIT_EDGE: begin
            if (lp_rise) begin
               next_ack_state = ACK_WAIT_PERIOD;
            end
         end
         ACK_WAIT_PERIOD: begin
            if (lp_rise) begin
               next_ack_state = ACK_IDLE;
               wake_ack       = 1'b1;
            end
         end
         default: begin
            next_ack_state = ACK_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ack_state <= ACK_IDLE;
      end else begin
         ack_state <= next_ack_state;
      end
   end

   // auto acknowledge, a new wakeup wins over the clear
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         lp_wakeup_status_out <= 1'b0;
      end else if (wake_rise) begin
         lp_wakeup_status_out <= 1'b1;
      end else if (wake_ack) begin
         lp_wakeup_status_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // status bit 20 read-only
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= READ_ZERO;
      end else if (reg_req_in.rd) begin
         reg_rdata_out <= READ_ZERO;
         case (reg_req_in.addr)
            PREFETCH_LEAD_TIME_ADDR:
               reg_rdata_out[LEAD_W-1:0] <= prefetch_lead_us_out;
            COARSE_TIMER_TARGET_ADDR:
               reg_rdata_out[COARSE_W-1:0] <= coarse_target;
            SLOT_TIMER_TARGET_ADDR:
               reg_rdata_out[BASE_W-1:0] <= slot_target;
            TIME_CAPTURE_TRIG_ADDR:
               reg_rdata_out[CAPTURE_BIT] <= capture_trigger;
            LINK_CONTROL_TWO_ADDR: begin
               reg_rdata_out[RSSI_SEL_BIT]     <= signal_strength_select;
               reg_rdata_out[WAKE_STAT_BIT]    <= lp_wakeup_status_out;
               reg_rdata_out[TEST_HI:TEST_LO]  <= test_bits_out;
            end
            BASE_TIME_COUNT_ADDR:
               reg_rdata_out[BASE_W-1:0] <= base_time_count;
            default: begin
               reg_rdata_out <= READ_ZERO;
            end
         endcase
      end else begin
         reg_rdata_out <= READ_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // written out rather than through hit(): a function body would read live values
   sequence capture_write_s;
      reg_req_in.wr && reg_req_in.addr == TIME_CAPTURE_TRIG_ADDR
      && reg_req_in.wdata[CAPTURE_BIT];
   endsequence

   sequence ack_wait_s;
      ack_state == ACK_WAIT_PERIOD && lp_rise && !wake_rise;
   endsequence

   lead_time_store_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.wr && reg_req_in.addr == PREFETCH_LEAD_TIME_ADDR
      |=> prefetch_lead_us_out == $past(reg_req_in.wdata[7:0]))
      else $error("prefetch lead time not stored");

   coarse_match_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      coarse_match_irq_out |-> $past(coarse_target) == $past(base_time_count_in[19:4])
                               && $past(base_time_count_in[3:0]) == 4'h0)
      else $error("coarse match without equal count");

   slot_match_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(slot_hit) |=> slot_match_irq_out)
      else $error("slot match pulse missing");

   capture_copy_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      capture_write_s ##1 capture_trigger
      |=> base_time_count == $past(base_time_count_in))
      else $error("base time count not captured");

   capture_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      capture_write_s |=> capture_trigger
      ##1 (!capture_trigger
           || $past(reg_req_in.wr && reg_req_in.addr == TIME_CAPTURE_TRIG_ADDR
                    && reg_req_in.wdata[CAPTURE_BIT])))
      else $error("capture trigger did not clear");

   rssi_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in |=> rssi_value_out == ($past(signal_strength_select) ? $past(rssi_avg_in)
                                                                    : $past(rssi_peak_in)))
      else $error("wrong signal strength source");

   wake_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.rd && reg_req_in.addr == LINK_CONTROL_TWO_ADDR
      |=> reg_rdata_out[20] == $past(lp_wakeup_status_out))
      else $error("wakeup status misreported");

   wake_ack_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ack_wait_s |=> !lp_wakeup_status_out)
      else $error("wakeup status not acknowledged");

   match_single_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      coarse_match_irq_out || slot_match_irq_out
      |=> !(coarse_match_irq_out && $past(coarse_match_irq_out))
          && !(slot_match_irq_out && $past(slot_match_irq_out)))
      else $error("match pulse repeated");

   coarse_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(coarse_hit) |=> coarse_match_irq_out)
      else $error("coarse match pulse missing");

   slot_equal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      slot_match_irq_out |-> $past(slot_target) == $past(base_time_count_in))
      else $error("slot match without equal count");

   lead_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_req_in.rd && reg_req_in.addr == PREFETCH_LEAD_TIME_ADDR
      |=> reg_rdata_out[31:LEAD_W] == 24'h00_0000
          && reg_rdata_out[LEAD_W-1:0] == $past(prefetch_lead_us_out))
      else $error("lead time misreported");

   wake_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      wake_rise |=> lp_wakeup_status_out)
      else $error("wakeup status not set");

   wake_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(lp_wakeup_status_out) |-> $past(wake_ack))
      else $error("wakeup status cleared without acknowledge");

endmodule : radio_base_time_targets

// ==== verif/radio_base_time_targets_tb.sv ====
/*
 * Self-checking bench for the radio base time target block: register
 * access, target matches, capture, strength select and wakeup status.
 * Assumes the design's own assertions run beside it; the bench drives
 * every port itself, with lp clock made from the system clock.
 */
`timescale 1ns/100ps
module radio_base_time_targets_tb;
   import radio_time_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int CYCLE_LIMIT = 5000;
   logic              sys_clk_in          = 1'b0;
   logic              rst_n_in            = 1'b0;
   reg_req_t          req                 = '0;
   logic [31:0]       reg_rdata_out;
   logic [BASE_W-1:0] base_time_count_in  = 27'h000_0001;
   logic [RSSI_W-1:0] rssi_peak_in        = 8'h11;
   logic [RSSI_W-1:0] rssi_avg_in         = 8'h22;
   logic              lp_clk_in           = 1'b0;
   logic              lp_wakeup_irq_in    = 1'b0;
   logic              radio_powered_up_in = 1'b0;
   logic [LEAD_W-1:0] prefetch_lead_us_out;
   logic              coarse_match_irq_out;
   logic              slot_match_irq_out;
   logic [RSSI_W-1:0] rssi_value_out;
   logic              lp_wakeup_status_out;
   logic [2:0]        test_bits_out;
   int                failures            = 0;
   int                comparisons         = 0;
   int                cycles              = 0;
   int                coarse_hits         = 0;
   int                slot_hits           = 0;
   logic [31:0]       rd;

   radio_base_time_targets DUT (
      .sys_clk_in           (sys_clk_in),
      .rst_n_in             (rst_n_in),
      .reg_req_in           (req),
      .reg_rdata_out        (reg_rdata_out),
      .base_time_count_in   (base_time_count_in),
      .rssi_peak_in         (rssi_peak_in),
      .rssi_avg_in          (rssi_avg_in),
      .lp_clk_in            (lp_clk_in),
      .lp_wakeup_irq_in     (lp_wakeup_irq_in),
      .radio_powered_up_in  (radio_powered_up_in),
      .prefetch_lead_us_out (prefetch_lead_us_out),
      .coarse_match_irq_out (coarse_match_irq_out),
      .slot_match_irq_out   (slot_match_irq_out),
      .rssi_value_out       (rssi_value_out),
      .lp_wakeup_status_out (lp_wakeup_status_out),
      .test_bits_out        (test_bits_out)
   );

   // ----------------------------------------------------------------
   // clocks, pulse counting, hang guard
   // ----------------------------------------------------------------
   always #10 sys_clk_in = ~sys_clk_in;

   // lp clock 8 system cycles a period, well above the 2+2 minimum;
   // made beside the cycle count so its read is never raced
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles % 4 == 0) begin
         lp_clk_in <= ~lp_clk_in;
      end
      if (coarse_match_irq_out === 1'b1) coarse_hits++;
      if (slot_match_irq_out === 1'b1) slot_hits++;
      if (cycles == CYCLE_LIMIT) begin
         failures++;
         $display("wrong value at %0t: run did not finish in time", $time);
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
      @(posedge sys_clk_in);
      req.addr  <= addr;
      req.wdata <= data;
      req.wr    <= 1'b1;
      @(posedge sys_clk_in);
      req.wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [31:0] addr, output logic [31:0] data);
      @(posedge sys_clk_in);
      req.addr <= addr;
      req.rd   <= 1'b1;
      @(posedge sys_clk_in);
      req.rd   <= 1'b0;
      // data stand for the cycle after the strobe; take them at its closing edge
      @(posedge sys_clk_in);
      data = reg_rdata_out;
   endtask : reg_read

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic read_check(input logic [31:0] addr, input logic [31:0] exp, input string what);
      logic [31:0] v;
      reg_read(addr, v);
      check(v, exp, what);
   endtask : read_check

   task automatic hold_count(input logic [BASE_W-1:0] v, input int n);
      base_time_count_in <= v;
      repeat (n) @(posedge sys_clk_in);
   endtask : hold_count

   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      // reset values and unmapped place
      read_check(PREFETCH_LEAD_TIME_ADDR, 32'h0000_0000, "lead reset");
      read_check(COARSE_TIMER_TARGET_ADDR, 32'h0000_0000, "coarse reset");
      read_check(SLOT_TIMER_TARGET_ADDR, 32'h0000_0000, "slot reset");
      read_check(TIME_CAPTURE_TRIG_ADDR, 32'h0000_0000, "trig reset");
      read_check(LINK_CONTROL_TWO_ADDR, 32'h0000_0000, "ctl2 reset");
      read_check(32'h4000_0100, 32'h0000_0000, "unmapped");
      $display("test reset values done");

      // lead time, reserved bits read zero
      reg_write(PREFETCH_LEAD_TIME_ADDR, 32'hffff_ffa5);
      read_check(PREFETCH_LEAD_TIME_ADDR, 32'h0000_00a5, "lead readback");
      check({24'h0, prefetch_lead_us_out}, 32'h0000_00a5, "lead port");
      $display("test lead time done");

      // coarse: low nibble nonzero, match, held, rearm, high bits ignored
      reg_write(COARSE_TIMER_TARGET_ADDR, 32'hffff_1234);
      read_check(COARSE_TIMER_TARGET_ADDR, 32'h0000_1234, "coarse rb");
      coarse_hits = 0;
      hold_count(27'h001_2341, 5);
      check(coarse_hits, 0, "coarse nibble");
      hold_count(27'h001_2340, 6);
      check(coarse_hits, 1, "coarse single");
      hold_count(27'h000_0001, 2);
      hold_count(27'h401_2340, 5);
      check(coarse_hits, 2, "coarse upper");
      hold_count(27'h001_3340, 5);
      check(coarse_hits, 2, "coarse miss");
      $display("test coarse target done");

      // slot: full width compare, one below misses
      reg_write(SLOT_TIMER_TARGET_ADDR, 32'hffff_ffff);
      read_check(SLOT_TIMER_TARGET_ADDR, 32'h07ff_ffff, "slot rb");
      slot_hits = 0;
      hold_count(27'h7ff_fffe, 5);
      check(slot_hits, 0, "slot near");
      hold_count(27'h7ff_ffff, 6);
      check(slot_hits, 1, "slot single");
      $display("test slot target done");

      // capture then self-clear of the trigger
      hold_count(27'h2a5_5a5a, 2);
      reg_write(TIME_CAPTURE_TRIG_ADDR, 32'h0000_0001);
      // the copy lands one cycle after the write; hold the count through it
      hold_count(27'h2a5_5a5a, 1);
      hold_count(27'h000_0001, 3);
      read_check(TIME_CAPTURE_TRIG_ADDR, 32'h0000_0000, "trig clear");
      read_check(BASE_TIME_COUNT_ADDR, 32'h02a5_5a5a, "capture value");
      $display("test capture done");

      // strength select, test bits, bit 20 not writable
      check({24'h0, rssi_value_out}, 32'h0000_0011, "peak default");
      // every other bit set, test bits kept at zero as software must
      reg_write(LINK_CONTROL_TWO_ADDR, 32'hfff1_ffff);
      read_check(LINK_CONTROL_TWO_ADDR, 32'h0020_0000, "ctl2 rb");
      check({24'h0, rssi_value_out}, 32'h0000_0022, "average sel");
      check({29'h0, test_bits_out}, 32'h0000_0000, "test bits");
      reg_write(LINK_CONTROL_TWO_ADDR, 32'h0000_0000);
      $display("test control two done");

      // wakeup status set, then acknowledged after power-up
      lp_wakeup_irq_in <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      read_check(LINK_CONTROL_TWO_ADDR, 32'h0010_0000, "wake set");
      radio_powered_up_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      check({31'h0, lp_wakeup_status_out}, 32'h0000_0001, "wake early");
      rd = 32'h0010_0000;
      // poll like a handler that waits for the cleared bit
      for (int i = 0; i < 20 && rd !== 32'h0000_0000; i++) begin
         reg_read(LINK_CONTROL_TWO_ADDR, rd);
      end
      check(rd, 32'h0000_0000, "wake ack");
      $display("test wakeup done");
      stop_test();
   end

endmodule : radio_base_time_targets_tb
